// ### src/dcm_pkg.sv
// package: constants and types for the dac control register and monitor mux
package dcm_pkg;
    // ======================================
    // command word fields
    localparam int          DCM_DATA_W        = 14;
    localparam int          DCM_FADDR_W       = 5;
    localparam logic [4:0]  DCM_FADDR_CTRL    = 5'h0C;
    localparam logic [4:0]  DCM_FADDR_MON     = 5'h0A;
    localparam logic [4:0]  DCM_FADDR_PDOWN   = 5'h08;
    localparam logic [4:0]  DCM_FADDR_PUP     = 5'h09;
    localparam logic [4:0]  DCM_FADDR_SRESET  = 5'h0F;
    // ======================================
    // control register field positions
    localparam int          DCM_CR_PD_AMP     = 13;
    localparam int          DCM_CR_REF_LVL    = 12;
    localparam int          DCM_CR_BOOST      = 11;
    localparam int          DCM_CR_REF_SRC    = 10;
    localparam int          DCM_CR_MON_EN     = 9;
    localparam int          DCM_CR_THERM_EN   = 8;
    localparam int          DCM_CR_TOG_LO     = 2;
    localparam int          DCM_CR_TOG_HI     = 5;
    localparam logic [13:0] DCM_CR_KEEP_MASK  = 14'h3F3C;
    // ======================================
    // reset values
    localparam logic [13:0] DCM_CR_RESET      = 14'h2000;
    localparam logic [5:0]  DCM_MON_RESET     = 6'h3F;
    // ======================================
    // monitor source decode
    localparam int          DCM_MON_ADDR_LO   = 8;
    localparam logic [5:0]  DCM_MON_EXT_FIRST = 6'h22;
    localparam logic [5:0]  DCM_MON_EXT_LAST  = 6'h25;
    localparam logic [5:0]  DCM_MON_TRISTATE  = 6'h3F;
    localparam int          DCM_NUM_CH        = 32;
    localparam int          DCM_NUM_GROUPS    = 4;
    localparam int          DCM_GROUP_SIZE    = 8;
    // ======================================
    // monitor route kinds
    typedef enum logic [1:0] {
        DCM_ROUTE_OFF  = 2'b00,
        DCM_ROUTE_CH   = 2'b01,
        DCM_ROUTE_EXT  = 2'b11
    } dcm_route_t;
endpackage

// ### src/dcm_cmd_if.sv
// interface: decoded command strobes passed to the toggle unit
`timescale 1ns/1ps
`default_nettype none
interface dcm_cmd_if;
    logic       load_pulse;
    logic [3:0] group_en;
    logic       clear_sel;
    modport ctrl (output load_pulse, output group_en, output clear_sel);
    modport tog  (input load_pulse, input group_en, input clear_sel);
endinterface
`default_nettype wire

// ### src/dcm_toggle_group.sv
// module: a/b register select for one group of eight channels
`timescale 1ns/1ps
`default_nettype none
module dcm_toggle_group
    import dcm_pkg::*;
#(
    parameter int GRP = 0
) (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // commands
    dcm_cmd_if.tog                         cmd,
    // result
    output logic [DCM_GROUP_SIZE-1:0]      ab_sel_o
);
    // ======================================
    // toggle state
    logic ab_r;
    logic ab_nxt;
    assign ab_nxt = cmd.clear_sel ? 1'b0 :
                    (cmd.load_pulse && cmd.group_en[GRP]) ? ~ab_r :
                    (cmd.group_en[GRP] ? ab_r : 1'b0);
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ab_r <= 1'b0;
        end else begin
            ab_r <= ab_nxt;
        end
    end
    assign ab_sel_o = {DCM_GROUP_SIZE{ab_r}};
endmodule // dcm_toggle_group
`default_nettype wire

// ### src/dcm_ctrl_top.sv
// module: control register, power state and channel monitor mux select
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - special functions decode only when both target select bits are zero
// - function 01100 writes control when read bit is 0, reads when 1
// - bit 13 picks power-down amp state: 1 high-z (default), 0 resistive
// - bit 12 picks internal reference level, default set by strap input
// - bit 11 turns amplifier current boost on, default off
// - bit 10 selects internal reference, 0 external is default
// - bit 9 set enables monitor so monitor commands route a source
// - bit 9 clear keeps monitor pin three-stated whatever the selection
// - bit 8 enables thermal guard; over-temperature powers all amps down
// - soft power-up re-enables amps only when die is below threshold
// - bits 7 and 6 are ignored on write
// - bits 1 and 0 are ignored on write
// - bits 5 to 2 each enable toggle mode for eight channels
// - bit 5 channels 24-31, 4 16-23, 3 8-15, 2 0-7
// - load strobe flips enabled channels between a and b registers
// - function 01010 takes source address in data bits 13 to 8
// - sources 0 to 31 route dac output channels 0 to 31
// - sources 34 to 37 route external inputs 1 to 4, others undefined
// - source 63 three-states the monitor pin
// - writes other than power-up (01001) are rejected in power-down and contents retained
module dcm_ctrl_top
    import dcm_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   resetn_i,
    // command port
    input  wire logic                   cmd_valid_i,
    input  wire logic                   cmd_read_i,
    input  wire logic                   target_select_high_i,
    input  wire logic                   target_select_low_i,
    input  wire logic [DCM_FADDR_W-1:0] function_address_bits_i,
    input  wire logic [DCM_DATA_W-1:0]  cmd_data_i,
    // device status inputs
    input  wire logic                   hw_powerdown_i,
    input  wire logic                   over_temp_i,
    input  wire logic                   ref_level_strap_i,
    input  wire logic                   load_outputs_strobe_i,
    // readback
    output logic [DCM_DATA_W-1:0]       rd_data_o,
    output logic                        rd_valid_o,
    // control outputs
    output logic                        powerdown_amp_state_bit_o,
    output logic                        internal_ref_level_bit_o,
    output logic                        amp_boost_bit_o,
    output logic                        ref_source_bit_o,
    output logic                        thermal_guard_enable_bit_o,
    output logic [3:0]                  toggle_group_en_o,
    output logic                        amps_powered_o,
    output logic                        thermal_shutdown_o,
    output logic [DCM_NUM_CH-1:0]       ab_select_o,
    // monitor mux
    output logic [4:0]                  mon_channel_sel_o,
    output logic [1:0]                  mon_ext_sel_o,
    output logic                        mon_route_ch_o,
    output logic                        mon_route_ext_o,
    output logic                        monitor_output_pin_oe_o
);
    // ======================================
    // command decode
    logic       sfr_hit;
    logic       is_ctrl_wr;
    logic       is_ctrl_rd;
    logic       is_mon_wr;
    logic       is_pdown;
    logic       is_pup;
    logic       is_sreset;
    logic       powered_down;
    logic       wr_allowed;
    logic       soft_pd_r;
    assign sfr_hit    = cmd_valid_i && !target_select_high_i && !target_select_low_i;
    assign powered_down = soft_pd_r || hw_powerdown_i;
    assign wr_allowed = sfr_hit && !cmd_read_i && !powered_down;
    assign is_ctrl_wr = wr_allowed && (function_address_bits_i == DCM_FADDR_CTRL);
    assign is_ctrl_rd = sfr_hit && cmd_read_i
                        && (function_address_bits_i == DCM_FADDR_CTRL);
    assign is_mon_wr  = wr_allowed && (function_address_bits_i == DCM_FADDR_MON);
    assign is_pdown   = wr_allowed && (function_address_bits_i == DCM_FADDR_PDOWN);
    assign is_pup     = sfr_hit && !cmd_read_i && (function_address_bits_i == DCM_FADDR_PUP);
    assign is_sreset  = wr_allowed && (function_address_bits_i == DCM_FADDR_SRESET);

    // ======================================
    // reset default capture of reference level strap
    logic       started_r;
    logic       soft_pd_nxt;
    logic       therm_sd_r;
    logic       therm_sd_nxt;
    logic [DCM_DATA_W-1:0] cr_r;
    logic [DCM_DATA_W-1:0] cr_nxt;
    logic [DCM_DATA_W-1:0] cr_default;
    assign cr_default = DCM_CR_RESET
                        | (DCM_DATA_W'(ref_level_strap_i) << DCM_CR_REF_LVL);
    assign cr_nxt = !started_r || is_sreset ? cr_default :
                    is_ctrl_wr ? (cmd_data_i & DCM_CR_KEEP_MASK) :
                    cr_r;

    // ======================================
    // power state
    assign therm_sd_nxt = (cr_r[DCM_CR_THERM_EN] && over_temp_i) ? 1'b1 :
                          (is_pup && !over_temp_i) ? 1'b0 :
                          therm_sd_r;
    assign soft_pd_nxt  = is_pdown ? 1'b1 :
                          is_pup ? 1'b0 :
                          soft_pd_r;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            started_r  <= 1'b0;
            cr_r       <= DCM_CR_RESET;
            soft_pd_r  <= 1'b0;
            therm_sd_r <= 1'b0;
        end else begin
            started_r  <= 1'b1;
            cr_r       <= cr_nxt;
            soft_pd_r  <= soft_pd_nxt;
            therm_sd_r <= therm_sd_nxt;
        end
    end

    // ======================================
    // monitor source
    logic [5:0] mon_src_r;
    logic [5:0] mon_src_nxt;
    logic [5:0] mon_addr;
    dcm_route_t route;
    logic       ext_hit;
    assign mon_addr    = cmd_data_i[DCM_MON_ADDR_LO +: 6];
    assign mon_src_nxt = (!started_r || is_sreset) ? DCM_MON_RESET :
                         is_mon_wr ? mon_addr : mon_src_r;
    assign ext_hit     = (mon_src_r >= DCM_MON_EXT_FIRST) && (mon_src_r <= DCM_MON_EXT_LAST);
    assign route = !cr_r[DCM_CR_MON_EN] ? DCM_ROUTE_OFF :
                   (mon_src_r == DCM_MON_TRISTATE) ? DCM_ROUTE_OFF :
                   !mon_src_r[5] ? DCM_ROUTE_CH :
                   ext_hit ? DCM_ROUTE_EXT : DCM_ROUTE_OFF;

    // ======================================
    // outputs
    logic [5:0] ext_off;
    assign ext_off = mon_src_r - DCM_MON_EXT_FIRST;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_src_r                  <= DCM_MON_RESET;
            rd_data_o                  <= '0;
            rd_valid_o                 <= 1'b0;
            mon_channel_sel_o          <= '0;
            mon_ext_sel_o              <= '0;
            mon_route_ch_o             <= 1'b0;
            mon_route_ext_o            <= 1'b0;
            monitor_output_pin_oe_o    <= 1'b0;
            amps_powered_o             <= 1'b0;
            thermal_shutdown_o         <= 1'b0;
        end else begin
            mon_src_r                  <= mon_src_nxt;
            rd_valid_o                 <= is_ctrl_rd;
            rd_data_o                  <= is_ctrl_rd ? cr_r : rd_data_o;
            mon_channel_sel_o          <= mon_src_r[4:0];
            mon_ext_sel_o              <= ext_off[1:0];
            mon_route_ch_o             <= (route == DCM_ROUTE_CH);
            mon_route_ext_o            <= (route == DCM_ROUTE_EXT);
            monitor_output_pin_oe_o    <= (route != DCM_ROUTE_OFF);
            amps_powered_o             <= started_r && !powered_down && !therm_sd_r;
            thermal_shutdown_o         <= therm_sd_r;
        end
    end

    // control register fields drive out from their own flops, loaded from cr_nxt on the same edge as cr_r
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            powerdown_amp_state_bit_o  <= 1'b1;
            internal_ref_level_bit_o   <= 1'b0;
            amp_boost_bit_o            <= 1'b0;
            ref_source_bit_o           <= 1'b0;
            thermal_guard_enable_bit_o <= 1'b0;
            toggle_group_en_o          <= '0;
        end else begin
            powerdown_amp_state_bit_o  <= cr_nxt[DCM_CR_PD_AMP];
            internal_ref_level_bit_o   <= cr_nxt[DCM_CR_REF_LVL];
            amp_boost_bit_o            <= cr_nxt[DCM_CR_BOOST];
            ref_source_bit_o           <= cr_nxt[DCM_CR_REF_SRC];
            thermal_guard_enable_bit_o <= cr_nxt[DCM_CR_THERM_EN];
            toggle_group_en_o          <= cr_nxt[DCM_CR_TOG_HI:DCM_CR_TOG_LO];
        end
    end

    // ======================================
    // toggle groups
    dcm_cmd_if cmd_bus ();
    assign cmd_bus.load_pulse = load_outputs_strobe_i && !powered_down;
    assign cmd_bus.group_en   = cr_r[DCM_CR_TOG_HI:DCM_CR_TOG_LO];
    assign cmd_bus.clear_sel  = !started_r || is_sreset;
    logic [DCM_NUM_CH-1:0] ab_sel;
    genvar g;
    generate
        for (g = 0; g < DCM_NUM_GROUPS; g++) begin : g_tog
            dcm_toggle_group #(.GRP(g)) u_grp (
                .core_clk_i (core_clk_i),
                .resetn_i   (resetn_i),
                .cmd        (cmd_bus.tog),
                .ab_sel_o   (ab_sel[g*DCM_GROUP_SIZE +: DCM_GROUP_SIZE])
            );
        end
    endgenerate
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ab_select_o <= '0;
        end else begin
            ab_select_o <= ab_sel;
        end
    end
endmodule // dcm_ctrl_top
`default_nettype wire

// ### verification/dcm_ctrl_asserts.sv
// checker: port assertions for the control register and monitor mux
`timescale 1ns/1ps
`default_nettype none
module dcm_ctrl_asserts
    import dcm_pkg::*;
(
    // clock, reset and commands
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_read_i,
    input wire logic        target_select_high_i,
    input wire logic        target_select_low_i,
    input wire logic [4:0]  function_address_bits_i,
    input wire logic [13:0] cmd_data_i,
    input wire logic        hw_powerdown_i,
    input wire logic        over_temp_i,
    // observed outputs
    input wire logic [13:0] rd_data_o,
    input wire logic        rd_valid_o,
    input wire logic        powerdown_amp_state_bit_o,
    input wire logic        internal_ref_level_bit_o,
    input wire logic        amp_boost_bit_o,
    input wire logic        ref_source_bit_o,
    input wire logic        thermal_guard_enable_bit_o,
    input wire logic [3:0]  toggle_group_en_o,
    input wire logic        amps_powered_o,
    input wire logic        thermal_shutdown_o,
    input wire logic [4:0]  mon_channel_sel_o,
    input wire logic        mon_route_ch_o,
    input wire logic        mon_route_ext_o,
    input wire logic        monitor_output_pin_oe_o
);
    // ======================================
    // decode of taken commands
    wire logic       sfr  = cmd_valid_i && !target_select_high_i && !target_select_low_i;
    wire logic       live = amps_powered_o && !hw_powerdown_i;
    wire logic       ctl  = sfr && function_address_bits_i == DCM_FADDR_CTRL;
    wire logic       wr_c = ctl && !cmd_read_i;
    wire logic       rd_c = ctl && cmd_read_i;
    wire logic       wr_m = sfr && !cmd_read_i && function_address_bits_i == DCM_FADDR_MON && live;
    wire logic [5:0] ma   = cmd_data_i[13:8];
    wire logic [8:0] cw   = {cmd_data_i[13:10], cmd_data_i[8], cmd_data_i[5:2]};
    wire logic [8:0] co   = {powerdown_amp_state_bit_o, internal_ref_level_bit_o, amp_boost_bit_o,
                             ref_source_bit_o, thermal_guard_enable_bit_o, toggle_group_en_o};
    wire logic [8:0] rb   = {rd_data_o[13:10], rd_data_o[8], rd_data_o[5:2]};
    logic            mon_en_r;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) mon_en_r <= 1'b0;
        else if (wr_c && live) mon_en_r <= cmd_data_i[DCM_CR_MON_EN];
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ======================================
    // assertions
    chk_ctrl_write: assert property (
        wr_c && live |=> co == $past(cw)) else $error("control write lost");
    chk_ctrl_read: assert property (
        rd_c |=> rd_valid_o && rb == $past(co) && {rd_data_o[7:6], rd_data_o[1:0]} == 4'h0)
        else $error("readback wrong");
    chk_wr_refused: assert property (
        wr_c && hw_powerdown_i |=> $stable(co)) else $error("write taken in power-down");
    chk_mon_channel: assert property (
        wr_m && mon_en_r && ma < 6'd32 |-> ##2 monitor_output_pin_oe_o && mon_route_ch_o
        && mon_channel_sel_o == $past(cmd_data_i[12:8], 2)) else $error("channel route wrong");
    chk_mon_external: assert property (
        wr_m && mon_en_r && ma inside {[6'd34:6'd37]} |-> ##2 monitor_output_pin_oe_o
        && mon_route_ext_o && !mon_route_ch_o) else $error("external route wrong");
    chk_mon_tristate: assert property (
        wr_m && ma == DCM_MON_TRISTATE |-> ##2 !monitor_output_pin_oe_o) else $error("pin driven");
    chk_mon_disabled: assert property (
        wr_m && !mon_en_r |-> ##2 !monitor_output_pin_oe_o) else $error("pin driven when off");
    chk_thermal_trip: assert property (
        thermal_guard_enable_bit_o && over_temp_i |-> ##2 thermal_shutdown_o ##[0:1] !amps_powered_o)
        else $error("no thermal shutdown");
    chk_thermal_hold: assert property (
        thermal_shutdown_o && over_temp_i |=> thermal_shutdown_o) else $error("hot restart");
    cov_read: cover property (rd_valid_o);
    cov_trip: cover property (thermal_shutdown_o);
    cov_route: cover property (wr_m && mon_en_r);
endmodule // dcm_ctrl_asserts
bind dcm_ctrl_top dcm_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### verification/dcm_host_model.sv
// model: host controller issuing special-function commands
`timescale 1ns/1ps
`default_nettype none
module dcm_host_model (
    // clock and command port
    input  wire logic        core_clk_i,
    output var  logic        cmd_valid_o,
    output var  logic        cmd_read_o,
    output var  logic [1:0]  target_sel_o,
    output var  logic [4:0]  func_o,
    output var  logic [13:0] data_o
);
    initial {cmd_valid_o, cmd_read_o, target_sel_o, func_o, data_o} = {4'h3, 5'h00, 14'h0000};
    // a request stands one cycle, then every qualifier is released inverted
    task automatic send(input logic rd, input logic [1:0] sel, input logic [4:0] f,
                        input logic [13:0] d);
        @(posedge core_clk_i);
        {cmd_valid_o, cmd_read_o, target_sel_o, func_o, data_o} <= {1'b1, rd, sel, f, d};
        @(posedge core_clk_i);
        {cmd_valid_o, cmd_read_o, target_sel_o, func_o, data_o} <= {1'b0, ~rd, ~sel, ~f, ~d};
    endtask
endmodule // dcm_host_model
`default_nettype wire

// ### verification/dcm_ctrl_top_tb.sv
// testbench: control register, power states, toggle groups and monitor mux
`timescale 1ns/1ps
`default_nettype none
module dcm_ctrl_top_tb
    import dcm_pkg::*;
;
    logic core_clk_i, resetn_i, cmd_valid_i, cmd_read_i, target_select_high_i, target_select_low_i;
    logic hw_powerdown_i, over_temp_i, ref_level_strap_i, load_outputs_strobe_i, rd_valid_o;
    logic powerdown_amp_state_bit_o, internal_ref_level_bit_o, amp_boost_bit_o, ref_source_bit_o;
    logic thermal_guard_enable_bit_o, amps_powered_o, thermal_shutdown_o, mon_route_ch_o;
    logic mon_route_ext_o, monitor_output_pin_oe_o;
    logic [1:0]  mon_ext_sel_o;
    logic [3:0]  toggle_group_en_o;
    logic [4:0]  function_address_bits_i, mon_channel_sel_o;
    logic [13:0] cmd_data_i, rd_data_o;
    logic [31:0] ab_select_o;
    logic [5:0]  a;
    int          n_fail = 0;
    int          cmp_count = 0;
    wire logic [8:0] co = {powerdown_amp_state_bit_o, internal_ref_level_bit_o, amp_boost_bit_o,
                           ref_source_bit_o, thermal_guard_enable_bit_o, toggle_group_en_o};
    localparam logic [27:0] ROWS [4] = '{{14'h3FFF, 14'h3F3C}, {14'h00C3, 14'h0000},
                                        {14'h2A28, 14'h2A28}, {14'h1543, 14'h1500}};
    localparam logic [5:0]  MONS [7] = '{6'h00, 6'h11, 6'h1F, 6'h22, 6'h23, 6'h24, 6'h25};
    dcm_ctrl_top DUT (.*);
    dcm_host_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_read_o(cmd_read_i),
        .target_sel_o({target_select_high_i, target_select_low_i}),
        .func_o(function_address_bits_i), .data_o(cmd_data_i));
    // ======================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    task automatic sfr(input logic [4:0] f, input logic [13:0] d, input int n);
        host.send(1'b0, 2'h0, f, d);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic rctl(input logic [13:0] e);
        host.send(1'b1, 2'h0, DCM_FADDR_CTRL, 14'h0000);
        #1;
        chk({rd_valid_o, rd_data_o}, {1'b1, e}, "readback");
    endtask
    task automatic wait_amps;
        int k;
        for (k = 0; k < 16 && amps_powered_o !== 1'b1; k++) @(posedge core_clk_i);
        if (k == 16) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ======================================
    // sequence
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        resetn_i = 1'b0;
        {hw_powerdown_i, over_temp_i, load_outputs_strobe_i, ref_level_strap_i} = 4'h1;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        sfr(5'h00, 14'h0000, 1);
        chk({co, monitor_output_pin_oe_o}, 10'h300, "defaults");
        foreach (ROWS[i]) begin
            sfr(DCM_FADDR_CTRL, ROWS[i][27:14], 0);
            chk(co, {ROWS[i][13:10], ROWS[i][8], ROWS[i][5:2]}, "control");
            rctl(ROWS[i][13:0]);
        end
        sfr(DCM_FADDR_CTRL, 14'h0200, 0);
        foreach (MONS[i]) begin
            a = MONS[i];
            sfr(DCM_FADDR_MON, {a, 8'hA5}, 2);
            chk({monitor_output_pin_oe_o, mon_route_ch_o, mon_route_ext_o}, {1'b1, ~a[5], a[5]}, "route");
            chk(a[5] ? mon_ext_sel_o : mon_channel_sel_o, a[5] ? {3'h0, a[1:0] - 2'h2} : a[4:0], "sel");
        end
        sfr(DCM_FADDR_MON, 14'h3F00, 2);
        chk(monitor_output_pin_oe_o, 1'b0, "tristate");
        sfr(DCM_FADDR_CTRL, 14'h0000, 0);
        sfr(DCM_FADDR_MON, 14'h0500, 2);
        chk(monitor_output_pin_oe_o, 1'b0, "disabled");
        for (int s = 1; s < 4; s++) begin
            host.send(1'b0, s[1:0], DCM_FADDR_CTRL, 14'h3F3C);
            #1;
            chk(co, 9'h000, "not special");
        end
        sfr(DCM_FADDR_CTRL, 14'h0014, 0);
        for (int p = 0; p < 2; p++) begin
            @(posedge core_clk_i);
            load_outputs_strobe_i <= 1'b1;
            @(posedge core_clk_i);
            load_outputs_strobe_i <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            #1;
            chk(ab_select_o, p ? 32'h0 : 32'h00FF00FF, "toggle");
        end
        @(posedge core_clk_i);
        hw_powerdown_i <= 1'b1;
        sfr(DCM_FADDR_CTRL, 14'h3F3C, 0);
        rctl(14'h0014);
        @(posedge core_clk_i);
        hw_powerdown_i <= 1'b0;
        sfr(DCM_FADDR_PDOWN, 14'h0000, 1);
        sfr(DCM_FADDR_CTRL, 14'h0000, 0);
        rctl(14'h0014);
        sfr(DCM_FADDR_PUP, 14'h0000, 0);
        wait_amps();
        sfr(DCM_FADDR_CTRL, 14'h0100, 0);
        @(posedge core_clk_i);
        over_temp_i <= 1'b1;
        sfr(5'h00, 14'h0000, 2);
        chk({thermal_shutdown_o, amps_powered_o}, 2'b10, "trip");
        sfr(DCM_FADDR_PUP, 14'h0000, 2);
        chk({thermal_shutdown_o, amps_powered_o}, 2'b10, "hot restart");
        @(posedge core_clk_i);
        over_temp_i <= 1'b0;
        sfr(DCM_FADDR_PUP, 14'h0000, 0);
        wait_amps();
        tally_and_finish();
    end
endmodule // dcm_ctrl_top_tb
`default_nettype wire
